// ==== logic/ccdc_pkg.sv ====
// ccdc_pkg: field layout, widths and reset values of the clock conditioning configuration word
// assumes: shared by the shift register top and its field decoder
package ccdc_pkg;
  localparam int unsigned CFG_W = 81;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [6:0] SHIFT_CNT_W1 = 7'h51; // 81 bits shifted
  localparam logic [6:0] SHIFT_CNT_RST = 7'h00;
  // field positions
  localparam int unsigned POS_RESET_EN = 80;
  localparam int unsigned POS_DYN_C = 79;
  localparam int unsigned POS_DYN_B = 78;
  localparam int unsigned POS_DYN_A = 77;
  localparam int unsigned POS_OSC_LO = 74;
  localparam int unsigned POS_STAT_C = 73;
  localparam int unsigned POS_STAT_B = 72;
  localparam int unsigned POS_STAT_A = 71;
  localparam int unsigned POS_OUTC_DLY_LO = 66;
  localparam int unsigned POS_OUTB_DLY_LO = 61;
  localparam int unsigned POS_GLC_DLY_LO = 56;
  localparam int unsigned POS_GLB_DLY_LO = 51;
  localparam int unsigned POS_GLA_DLY_LO = 46;
  localparam int unsigned POS_XDLY = 45;
  localparam int unsigned POS_FB_DLY_LO = 40;
  localparam int unsigned POS_FB_SRC_LO = 38;
  localparam int unsigned POS_OUTC_MUX_LO = 35;
  localparam int unsigned POS_OUTB_MUX_LO = 32;
  localparam int unsigned POS_OUTA_MUX_LO = 29;
  localparam int unsigned POS_OUTC_DIV_LO = 24;
  localparam int unsigned POS_OUTB_DIV_LO = 19;
  localparam int unsigned POS_OUTA_DIV_LO = 14;
  localparam int unsigned POS_FB_DIV_LO = 7;
  localparam int unsigned POS_IN_DIV_LO = 0;
  // value after reset of the active word
  localparam logic [80:0] CFG_RST = 81'h0;

  typedef struct packed {
    logic reset_enable;
    logic dynamic_select_out_c;
    logic dynamic_select_out_b;
    logic dynamic_select_out_a;
    logic [2:0] oscillator_range_select;
    logic static_select_out_c;
    logic static_select_out_b;
    logic static_select_out_a;
    logic [4:0] out_c_delay;
    logic [4:0] out_b_delay;
    logic [4:0] global_c_delay;
    logic [4:0] global_b_delay;
    logic [4:0] global_a_delay;
    logic extra_delay_select;
    logic [4:0] feedback_delay;
    logic [1:0] feedback_source_select;
    logic [2:0] out_c_mux;
    logic [2:0] out_b_mux;
    logic [2:0] out_a_mux;
    logic [4:0] out_c_divider;
    logic [4:0] out_b_divider;
    logic [4:0] out_a_divider;
    logic [6:0] feedback_divider;
    logic [6:0] input_divider;
  } ccdc_cfg_t;

  // serial port from the fabric module
  typedef struct packed {
    logic shift;
    logic data;
    logic load;
  } ccdc_ser_t;
endpackage

// ==== logic/ccdc_field_decode.sv ====
// ccdc_field_decode: splits the 81-bit word into named clock conditioning fields
// assumes: purely combinational, word comes from active_r or the static_word_i input
`timescale 1ns/1ns
`default_nettype none
module ccdc_field_decode
(
  // raw word
  input wire logic [80:0] word_i,
  // decoded fields
  output wire ccdc_pkg::ccdc_cfg_t cfg_o
);
  // field extraction at fixed positions
  assign cfg_o.reset_enable = word_i[ccdc_pkg::POS_RESET_EN];
  assign cfg_o.dynamic_select_out_c = word_i[ccdc_pkg::POS_DYN_C];
  assign cfg_o.dynamic_select_out_b = word_i[ccdc_pkg::POS_DYN_B];
  assign cfg_o.dynamic_select_out_a = word_i[ccdc_pkg::POS_DYN_A];
  assign cfg_o.oscillator_range_select = word_i[ccdc_pkg::POS_OSC_LO +: 3];
  assign cfg_o.static_select_out_c = word_i[ccdc_pkg::POS_STAT_C];
  assign cfg_o.static_select_out_b = word_i[ccdc_pkg::POS_STAT_B];
  assign cfg_o.static_select_out_a = word_i[ccdc_pkg::POS_STAT_A];
  assign cfg_o.out_c_delay = word_i[ccdc_pkg::POS_OUTC_DLY_LO +: 5];
  assign cfg_o.out_b_delay = word_i[ccdc_pkg::POS_OUTB_DLY_LO +: 5];
  assign cfg_o.global_c_delay = word_i[ccdc_pkg::POS_GLC_DLY_LO +: 5];
  assign cfg_o.global_b_delay = word_i[ccdc_pkg::POS_GLB_DLY_LO +: 5];
  assign cfg_o.global_a_delay = word_i[ccdc_pkg::POS_GLA_DLY_LO +: 5];
  assign cfg_o.extra_delay_select = word_i[ccdc_pkg::POS_XDLY];
  assign cfg_o.feedback_delay = word_i[ccdc_pkg::POS_FB_DLY_LO +: 5];
  assign cfg_o.feedback_source_select = word_i[ccdc_pkg::POS_FB_SRC_LO +: 2];
  assign cfg_o.out_c_mux = word_i[ccdc_pkg::POS_OUTC_MUX_LO +: 3];
  assign cfg_o.out_b_mux = word_i[ccdc_pkg::POS_OUTB_MUX_LO +: 3];
  assign cfg_o.out_a_mux = word_i[ccdc_pkg::POS_OUTA_MUX_LO +: 3];
  assign cfg_o.out_c_divider = word_i[ccdc_pkg::POS_OUTC_DIV_LO +: 5];
  assign cfg_o.out_b_divider = word_i[ccdc_pkg::POS_OUTB_DIV_LO +: 5];
  assign cfg_o.out_a_divider = word_i[ccdc_pkg::POS_OUTA_DIV_LO +: 5];
  assign cfg_o.feedback_divider = word_i[ccdc_pkg::POS_FB_DIV_LO +: 7];
  assign cfg_o.input_divider = word_i[ccdc_pkg::POS_IN_DIV_LO +: 7];
endmodule // ccdc_field_decode
`default_nettype wire

// ==== logic/ccdc_top.sv ====
// ccdc_top: dynamic configuration shift register of the clock conditioning block
// assumes: fabric module drives shift/data/load on clk_sys_i; static word is a strap level
`timescale 1ns/1ns
`default_nettype none
module ccdc_top
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // serial port from fabric module, same clock
  input wire ccdc_pkg::ccdc_ser_t ser_i,
  // source select and static switch word
  input wire logic dyn_mode_i,
  input wire logic [80:0] static_word_i,
  // scan return toward the fabric
  output logic ser_out_o,
  output logic [80:0] shadow_o,
  output logic load_done_o,
  output logic shift_full_o,
  // active configuration
  output var ccdc_pkg::ccdc_cfg_t cfg_o
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [80:0] shift_r;
  logic [80:0] shift_nxt;
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [80:0] active_r;
  logic [80:0] active_nxt;
  logic [2:0] mode_sync_r;
  logic mode_r;
  logic ser_out_r;
  logic load_done_r;
  logic full_r;
  logic full_nxt;
  logic full_w;
  logic load_ok_w;
  logic [80:0] sel_word_w;
  ccdc_pkg::ccdc_cfg_t cfg_w;
  ccdc_pkg::ccdc_cfg_t cfg_r;

  ////////////////////////////////////////////////////////////////////////
  // shift path decode
  assign full_w = (cnt_r == ccdc_pkg::SHIFT_CNT_W1);
  assign load_ok_w = ser_i.load && full_w && !ser_i.shift;
  assign full_nxt = (cnt_nxt == ccdc_pkg::SHIFT_CNT_W1);
  assign shift_nxt = ser_i.shift ? {ser_i.data, shift_r[80:1]} : shift_r;
  assign cnt_nxt = ser_i.shift ? (full_w ? cnt_r : cnt_r + 7'h01) :
                   (load_ok_w ? ccdc_pkg::SHIFT_CNT_RST : cnt_r);
  assign active_nxt = load_ok_w ? shift_r : active_r;
  // source select between dynamic and static word
  assign sel_word_w = mode_r ? active_r : static_word_i;

  // shift register, bit count, active word
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      shift_r <= ccdc_pkg::CFG_RST;
      cnt_r <= ccdc_pkg::SHIFT_CNT_RST;
      active_r <= ccdc_pkg::CFG_RST;
    end
    else
    begin
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      active_r <= active_nxt;
    end
  end

  // mode pin synchroniser, three stages
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mode_sync_r <= 3'h0;
      mode_r <= 1'b0;
    end
    else
    begin
      mode_sync_r <= {mode_sync_r[1:0], dyn_mode_i};
      if (mode_sync_r[1] == mode_sync_r[2])
      begin
        mode_r <= mode_sync_r[2];
      end
    end
  end

  // field decoding of selected word
  ccdc_field_decode u_dec
  (
    .word_i(sel_word_w),
    .cfg_o(cfg_w)
  );

  // registered outputs back to the fabric
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ser_out_r <= 1'b0;
      load_done_r <= 1'b0;
      full_r <= 1'b0;
      cfg_r <= '0;
    end
    else
    begin
      ser_out_r <= shift_nxt[0];
      load_done_r <= load_ok_w;
      full_r <= full_nxt;
      cfg_r <= cfg_w;
    end
  end

  assign ser_out_o = ser_out_r;
  assign shadow_o = shift_r;
  assign load_done_o = load_done_r;
  assign shift_full_o = full_r;
  assign cfg_o = cfg_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_load_needs_full;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      ser_i.load && !full_w && !ser_i.shift |=> active_r == $past(active_r);
  endproperty
  a_load_needs_full: assert property (p_load_needs_full) else $error("partial word loaded");

  property p_load_takes;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      load_ok_w |=> active_r == $past(shift_r) && cnt_r == 7'h00 && load_done_o;
  endproperty
  a_load_takes: assert property (p_load_takes) else $error("load not applied");

  property p_shift_moves;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      ser_i.shift |=> shift_r[80] == $past(ser_i.data) && shift_r[79:0] == $past(shift_r[80:1]);
  endproperty
  a_shift_moves: assert property (p_shift_moves) else $error("shift wrong");

  property p_shift_keeps_active;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      ser_i.shift |=> $stable(active_r);
  endproperty
  a_shift_keeps_active: assert property (p_shift_keeps_active) else $error("active changed by shift");

  property p_dyn_fields;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      mode_r && $stable(active_r) |=> cfg_o.reset_enable == $past(active_r[80]) &&
        cfg_o.oscillator_range_select == $past(active_r[76:74]);
  endproperty
  a_dyn_fields: assert property (p_dyn_fields) else $error("upper fields wrong");

  property p_delay_fields;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      mode_r && $stable(active_r) |=> cfg_o.out_c_delay == $past(active_r[70:66]) &&
        cfg_o.feedback_delay == $past(active_r[44:40]);
  endproperty
  a_delay_fields: assert property (p_delay_fields) else $error("delay fields wrong");

  property p_div_fields;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      mode_r && $stable(active_r) |=> cfg_o.feedback_divider == $past(active_r[13:7]) &&
        cfg_o.input_divider == $past(active_r[6:0]);
  endproperty
  a_div_fields: assert property (p_div_fields) else $error("divider fields wrong");

  property p_static_src;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !mode_r |=> cfg_o.feedback_source_select == $past(static_word_i[39:38]);
  endproperty
  a_static_src: assert property (p_static_src) else $error("static word not used");

  property p_all_bits;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      1'b1 |=> cfg_o == $past(sel_word_w);
  endproperty
  a_all_bits: assert property (p_all_bits) else $error("word not fully mapped");

  property p_count_steps;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      ser_i.shift && !full_w |=> cnt_r == $past(cnt_r) + 7'h01;
  endproperty
  a_count_steps: assert property (p_count_steps) else $error("bit count not advanced");

  property p_count_saturates;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      ser_i.shift && full_w |=> full_w;
  endproperty
  a_count_saturates: assert property (p_count_saturates) else $error("bit count left full");

  property p_idle_keeps_shift;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !ser_i.shift |=> $stable(shift_r);
  endproperty
  a_idle_keeps_shift: assert property (p_idle_keeps_shift) else $error("shift register moved while idle");

  property p_scan_out;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      1'b1 |-> ser_out_o == shift_r[0];
  endproperty
  a_scan_out: assert property (p_scan_out) else $error("scan out not bit 0");

  property p_no_load_pulse;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !load_ok_w |=> !load_done_o;
  endproperty
  a_no_load_pulse: assert property (p_no_load_pulse) else $error("load pulse without load");

  property p_static_all;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !mode_r |=> cfg_o == $past(static_word_i);
  endproperty
  a_static_all: assert property (p_static_all) else $error("static word not applied");

  property p_full_flag;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      1'b1 |-> shift_full_o == full_w;
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag out of step");
endmodule // ccdc_top
`default_nettype wire

// ==== tb/ccdc_fabric_model.sv ====
// ccdc_fabric_model: fabric-side module that streams a word into the shift register
// assumes: same clock as the block, started by a one-cycle start level
`timescale 1ns/1ns
`default_nettype none
module ccdc_fabric_model
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // command from the bench
  input wire logic start_i,
  input wire logic [80:0] word_i,
  input wire logic [6:0] nbits_i,
  // serial port toward the block
  output var ccdc_pkg::ccdc_ser_t ser_o,
  output var logic busy_o
);
  // shift lsb first, then try one load; idle data shows the inverse of the last bit
  initial
  begin
    ser_o = '0;
    busy_o = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (start_i && rstn_i)
      begin
        busy_o <= 1'b1;
        for (int i = 0; i < nbits_i; i++)
        begin
          ser_o <= '{shift: 1'b1, data: word_i[i], load: 1'b0};
          @(posedge clk_i);
        end
        ser_o <= '{shift: 1'b0, data: ~ser_o.data, load: 1'b1};
        @(posedge clk_i);
        ser_o.load <= 1'b0;
        busy_o <= 1'b0;
      end
    end
  end
endmodule // ccdc_fabric_model
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: self-checking bench for the configuration shift register
// assumes: ccdc_pkg compiled first, fabric model drives the serial port
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct {logic [80:0] w; logic rst; logic [2:0] osc; logic [4:0] cdly;
    logic [1:0] fsel; logic [6:0] fdiv; logic [6:0] idiv;} ccdc_row_t;
  localparam logic [80:0] STAT_W = 81'h0_5a5a_3c3c_0f0f_1234_5678;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic dyn_mode_i = 1'b0;
  logic start = 1'b0;
  logic [80:0] word = 81'h0;
  logic [6:0] nbits = 7'h51;
  ccdc_pkg::ccdc_ser_t ser;
  logic busy, ser_out_o, load_done_o, shift_full_o, seen, seen_full;
  logic [80:0] shadow_o;
  ccdc_pkg::ccdc_cfg_t cfg_o;
  int bad_count = 0;
  int comparisons = 0;
  ccdc_row_t rows[5] = '{
    '{81'h1 << 80, 1'h1, 3'h0, 5'h00, 2'h0, 7'h00, 7'h00},
    '{(81'h5 << 74) | (81'h1b << 66), 1'h0, 3'h5, 5'h1b, 2'h0, 7'h00, 7'h00},
    '{(81'h2 << 38) | 81'h7f, 1'h0, 3'h0, 5'h00, 2'h2, 7'h00, 7'h7f},
    '{(81'h55 << 7) | 81'h01, 1'h0, 3'h0, 5'h00, 2'h0, 7'h55, 7'h01},
    '{{81{1'b1}}, 1'h1, 3'h7, 5'h1f, 2'h3, 7'h7f, 7'h7f}};

  // clock
  initial
  begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  ccdc_top u_ccdc_top (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ser_i(ser), .dyn_mode_i(dyn_mode_i),
    .static_word_i(STAT_W), .ser_out_o(ser_out_o), .shadow_o(shadow_o), .load_done_o(load_done_o),
    .shift_full_o(shift_full_o), .cfg_o(cfg_o));
  ccdc_fabric_model u_ccdc_fabric_model (.clk_i(clk_sys_i), .rstn_i(rstn_i), .start_i(start),
    .word_i(word), .nbits_i(nbits), .ser_o(ser), .busy_o(busy));

  task automatic check(input string what, input logic [80:0] got, input logic [80:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // stream one word through the model and note any load pulse
  task automatic send(input logic [80:0] w, input logic [6:0] n);
    int k;
    k = 0;
    seen = 1'b0;
    seen_full = 1'b0;
    @(posedge clk_sys_i);
    word <= w;
    nbits <= n;
    start <= 1'b1;
    @(posedge clk_sys_i);
    start <= 1'b0;
    @(posedge clk_sys_i);
    // watch the one-cycle load pulse and the full flag while the model works
    while (busy && k < 200)
    begin
      @(posedge clk_sys_i);
      #1 seen |= load_done_o;
      seen_full |= shift_full_o;
      k++;
    end
    check("send finished", {80'h0, busy}, 81'h0);
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #200000;
    bad_count++;
    final_report();
  end

  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    #1 check("cfg in reset", cfg_o, 81'h0);
    @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1 check("static cfg", cfg_o, STAT_W);
    @(posedge clk_sys_i);
    dyn_mode_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    #1 check("dynamic cfg after reset", cfg_o, ccdc_pkg::CFG_RST);
    $display("reset and static source done");
    foreach (rows[i])
    begin
      send(rows[i].w, 7'h51);
      check("load pulse", {80'h0, seen}, 81'h1);
      check("full before load", {80'h0, seen_full}, 81'h1);
      check("cfg word", cfg_o, rows[i].w);
      check("reset enable", {80'h0, cfg_o.reset_enable}, {80'h0, rows[i].rst});
      check("osc range", {78'h0, cfg_o.oscillator_range_select}, {78'h0, rows[i].osc});
      check("out c delay", {76'h0, cfg_o.out_c_delay}, {76'h0, rows[i].cdly});
      check("fb source", {79'h0, cfg_o.feedback_source_select}, {79'h0, rows[i].fsel});
      check("fb divider", {74'h0, cfg_o.feedback_divider}, {74'h0, rows[i].fdiv});
      check("in divider", {74'h0, cfg_o.input_divider}, {74'h0, rows[i].idiv});
      check("shadow", shadow_o, rows[i].w);
      check("scan out", {80'h0, ser_out_o}, {80'h0, rows[i].w[0]});
      $display("row %0d done", i);
    end
    send(81'h0_1111_2222_3333_4444_5555, 7'h28);
    check("partial no pulse", {80'h0, seen}, 81'h0);
    check("partial never full", {80'h0, seen_full}, 81'h0);
    check("partial not full", {80'h0, shift_full_o}, 81'h0);
    check("partial cfg kept", cfg_o, rows[4].w);
    $display("partial shift done");
    send(81'h0_1111_2222_3333_4444_5555, 7'h51);
    check("reload cfg", cfg_o, 81'h0_1111_2222_3333_4444_5555);
    check("reload pulse", {80'h0, seen}, 81'h1);
    check("overflow full", {80'h0, seen_full}, 81'h1);
    @(posedge clk_sys_i);
    dyn_mode_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1 check("back to static", cfg_o, STAT_W);
    $display("reload and source switch done");
    // reset in mid-run, then the static word again
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    @(posedge clk_sys_i);
    #1 check("mid reset cfg", cfg_o, ccdc_pkg::CFG_RST);
    check("mid reset shadow", shadow_o, ccdc_pkg::CFG_RST);
    check("mid reset full", {80'h0, shift_full_o}, 81'h0);
    @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1 check("static after mid reset", cfg_o, STAT_W);
    $display("mid-run reset done");
    final_report();
  end
endmodule // testbench
`default_nettype wire
